// [core/tomc_pkg.sv]
// Purpose: shared constants and types for the touch output mode block
// Assumes: 40 MHz system clock
// Notes:   option byte fields, register map and timing counts
package tomc_pkg;

  localparam int unsigned CLK_HZ = 40_000_000;

  // apb register byte addresses
  localparam logic [7:0] ADDR_MODE_OPT   = 8'h00;
  localparam logic [7:0] ADDR_SAMPLE_OPT = 8'h04;
  localparam logic [7:0] ADDR_STATUS     = 8'h08;
  localparam logic [7:0] ADDR_SIGNAL     = 8'h0c;
  localparam logic [7:0] ADDR_REF        = 8'h10;
  localparam logic [7:0] ADDR_OTP_MODE   = 8'h14;
  localparam logic [7:0] ADDR_OTP_SAMPLE = 8'h18;

  localparam logic [7:0] OPT_RESET = 8'h00;

  // field positions, mode/threshold byte
  localparam int POWER_HI  = 7;
  localparam int POWER_LO  = 6;
  localparam int THR_HI    = 5;
  localparam int THR_LO    = 4;
  localparam int FRZ_HI    = 3;
  localparam int FRZ_LO    = 2;
  localparam int OUTM_HI   = 1;
  localparam int OUTM_LO   = 0;
  // field positions, sampling/transfer byte
  localparam int SAMPLE_BIT = 2;
  localparam int RATE_BIT   = 1;

  typedef enum logic [1:0] {
    TOMC_PWR_LP_ZOOM  = 2'b00,
    TOMC_PWR_NORMAL   = 2'b01,
    TOMC_PWR_XLP_ZOOM = 2'b10,
    TOMC_PWR_XLP      = 2'b11
  } tomc_power_type;

  typedef enum logic [1:0] {
    TOMC_THR_STD_PROX  = 2'b00,
    TOMC_THR_STD_TOUCH = 2'b01,
    TOMC_THR_SEN_PROX  = 2'b10,
    TOMC_THR_SEN_TOUCH = 2'b11
  } tomc_thresh_type;

  typedef enum logic [1:0] {
    TOMC_FRZ_15S      = 2'b00,
    TOMC_FRZ_45S      = 2'b01,
    TOMC_FRZ_RESERVED = 2'b10,
    TOMC_FRZ_INFINITE = 2'b11
  } tomc_freeze_type;

  typedef enum logic [1:0] {
    TOMC_OUT_ACTIVE  = 2'b00,
    TOMC_OUT_TOGGLE  = 2'b01,
    TOMC_OUT_LATCH3  = 2'b10,
    TOMC_OUT_LATCH30 = 2'b11
  } tomc_outmode_type;

  typedef struct packed {
    tomc_power_type   power;
    tomc_thresh_type  thresh;
    tomc_freeze_type  freeze;
    tomc_outmode_type outmode;
    logic             fast_sample;
    logic             fast_transfer;
  } tomc_cfg_type;

  typedef struct packed {
    logic [7:0]  paddr;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] pwdata;
  } tomc_apb_req_type;

  // time base: 1 ms tick
  localparam int unsigned TICK_US       = 1000;
  localparam int unsigned TICK_CYCLES   = (CLK_HZ / 1_000_000) * TICK_US;
  // times in ms
  localparam int unsigned SAMPLE_SLOW_MS = 20;
  localparam int unsigned SAMPLE_FAST_MS = 10;
  localparam int unsigned LATCH3_MS      = 3000;
  localparam int unsigned LATCH30_MS     = 30000;
  localparam int unsigned FRZ15_MS       = 15000;
  localparam int unsigned FRZ45_MS       = 45000;
  localparam int unsigned MIN_HIGH_MS    = 20;
  localparam logic [15:0] MS_W_ONE       = 16'h0001;

  // charge transfer rates in kHz
  localparam int unsigned XFER_SLOW_KHZ = 125;
  localparam int unsigned XFER_FAST_KHZ = 250;

  // burst spacing in sampling periods
  localparam logic [4:0] SKIP_NORMAL = 5'h01;
  localparam logic [4:0] SKIP_LP     = 5'h05;
  localparam logic [4:0] SKIP_XLP    = 5'h11;

  // threshold magnitudes in counts, ordered by sensitivity
  localparam logic [11:0] THR_SEN_PROX_CNT  = 12'h004;
  localparam logic [11:0] THR_STD_PROX_CNT  = 12'h008;
  localparam logic [11:0] THR_SEN_TOUCH_CNT = 12'h010;
  localparam logic [11:0] THR_STD_TOUCH_CNT = 12'h020;

endpackage

// [core/tomc_ms_timer.sv]
// Purpose: millisecond down counter, loaded and run off the shared tick
// Assumes: tick is a one-cycle pulse every millisecond
// Notes:   done is high while the count is zero
`timescale 1ns/1ps
`default_nettype none
module tomc_ms_timer
(
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset_n,
  // control
  input  wire logic        load,
  input  wire logic [15:0] load_ms,
  input  wire logic        tick,
  // status
  output logic             done
);

  logic [15:0] count_q;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      count_q <= 16'h0000;
    else if (load)
      count_q <= load_ms;
    else if (tick && count_q != 16'h0000)
      count_q <= count_q - tomc_pkg::MS_W_ONE;
  end

  assign done = (count_q == 16'h0000);

endmodule
`default_nettype wire

// [core/tomc_top.sv]
// Purpose: option decode and detect output shaping for a capacitive sensor
// Assumes: acquisition supplies one signal sample per burst; sys_clk 40 MHz
// Notes:   option bytes are captured once after reset release
//
// Added by the designer: the APB register port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module tomc_top
(
  // clock and reset
  input  wire logic                     sys_clk,
  input  wire logic                     reset_n,
  // one-time programmable option bytes
  input  wire logic [7:0]               mode_threshold_options,
  input  wire logic [7:0]               sampling_transfer_options,
  // acquisition interface
  input  wire logic [11:0]              signal_level,
  input  wire logic                     sample_valid,
  output logic                          burst_request,
  output logic                          charge_transfer_fast,
  // apb slave
  input  wire tomc_pkg::tomc_apb_req_type apb_req,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // detection output pin
  output logic                          detect_output_pin
);

  tomc_pkg::tomc_cfg_type cfg_q;
  logic        cfg_loaded_q;
  logic [7:0]  otp_mode_q;
  logic [7:0]  otp_sample_q;
  logic [15:0] tick_cnt_q;
  logic        tick;
  logic [4:0]  ms_in_period_q;
  logic [4:0]  period_ms;
  logic        period_end;
  logic [4:0]  skip_cnt_q;
  logic [4:0]  skip_target;
  logic        awake_q;
  logic [11:0] ref_q;
  logic [11:0] sig_q;
  logic [11:0] thr_cnt;
  logic        detect_q;
  logic        detect_prev_q;
  logic        rise;
  logic        fall;
  logic        frz_load;
  logic [15:0] frz_ms;
  logic        frz_done;
  logic        frz_expired;
  logic        hold_load;
  logic [15:0] hold_ms;
  logic        hold_done;
  logic        minh_done;
  logic        out_q;
  logic        out_d;
  logic        apb_access;
  logic        apb_wr;
  logic        addr_ok;

  // options captured in a clocked process after release
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cfg_loaded_q <= 1'b0;
      otp_mode_q   <= tomc_pkg::OPT_RESET;
      otp_sample_q <= tomc_pkg::OPT_RESET;
    end
    else if (!cfg_loaded_q)
    begin
      cfg_loaded_q <= 1'b1;
      otp_mode_q   <= mode_threshold_options;
      otp_sample_q <= sampling_transfer_options;
    end
  end

  // decoded config, rewritable over apb for bring-up
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      cfg_q <= '0;
    else if (cfg_loaded_q == 1'b0)
    begin
      cfg_q.power         <= tomc_pkg::tomc_power_type'(
        mode_threshold_options[tomc_pkg::POWER_HI:tomc_pkg::POWER_LO]);
      cfg_q.thresh        <= tomc_pkg::tomc_thresh_type'(
        mode_threshold_options[tomc_pkg::THR_HI:tomc_pkg::THR_LO]);
      cfg_q.freeze        <= tomc_pkg::tomc_freeze_type'(
        mode_threshold_options[tomc_pkg::FRZ_HI:tomc_pkg::FRZ_LO]);
      cfg_q.outmode       <= tomc_pkg::tomc_outmode_type'(
        mode_threshold_options[tomc_pkg::OUTM_HI:tomc_pkg::OUTM_LO]);
      cfg_q.fast_sample   <= sampling_transfer_options[tomc_pkg::SAMPLE_BIT];
      cfg_q.fast_transfer <= sampling_transfer_options[tomc_pkg::RATE_BIT];
    end
    else if (apb_wr && apb_req.paddr == tomc_pkg::ADDR_MODE_OPT)
    begin
      cfg_q.power   <= tomc_pkg::tomc_power_type'(
        apb_req.pwdata[tomc_pkg::POWER_HI:tomc_pkg::POWER_LO]);
      cfg_q.thresh  <= tomc_pkg::tomc_thresh_type'(
        apb_req.pwdata[tomc_pkg::THR_HI:tomc_pkg::THR_LO]);
      cfg_q.freeze  <= tomc_pkg::tomc_freeze_type'(
        apb_req.pwdata[tomc_pkg::FRZ_HI:tomc_pkg::FRZ_LO]);
      cfg_q.outmode <= tomc_pkg::tomc_outmode_type'(
        apb_req.pwdata[tomc_pkg::OUTM_HI:tomc_pkg::OUTM_LO]);
    end
    else if (apb_wr && apb_req.paddr == tomc_pkg::ADDR_SAMPLE_OPT)
    begin
      cfg_q.fast_sample   <= apb_req.pwdata[tomc_pkg::SAMPLE_BIT];
      cfg_q.fast_transfer <= apb_req.pwdata[tomc_pkg::RATE_BIT];
    end
  end

  assign charge_transfer_fast = cfg_q.fast_transfer;

  // millisecond time base
  assign tick = (tick_cnt_q == 16'(tomc_pkg::TICK_CYCLES - 1));

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      tick_cnt_q <= 16'h0000;
    else if (tick)
      tick_cnt_q <= 16'h0000;
    else
      tick_cnt_q <= tick_cnt_q + 16'h0001;
  end

  // sampling period
  assign period_ms  = cfg_q.fast_sample ? 5'(tomc_pkg::SAMPLE_FAST_MS)
                                        : 5'(tomc_pkg::SAMPLE_SLOW_MS);
  assign period_end = tick && (ms_in_period_q == period_ms - 5'h01);

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      ms_in_period_q <= 5'h00;
    else if (period_end)
      ms_in_period_q <= 5'h00;
    else if (tick)
      ms_in_period_q <= ms_in_period_q + 5'h01;
  end

  // burst spacing per power mode
  always_comb
  begin
    unique case (cfg_q.power)
      tomc_pkg::TOMC_PWR_NORMAL:   skip_target = tomc_pkg::SKIP_NORMAL;
      tomc_pkg::TOMC_PWR_LP_ZOOM:  skip_target = awake_q ? tomc_pkg::SKIP_NORMAL
                                                         : tomc_pkg::SKIP_LP;
      tomc_pkg::TOMC_PWR_XLP_ZOOM: skip_target = awake_q ? tomc_pkg::SKIP_NORMAL
                                                         : tomc_pkg::SKIP_XLP;
      tomc_pkg::TOMC_PWR_XLP:      skip_target = tomc_pkg::SKIP_XLP;
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      skip_cnt_q <= 5'h00;
    else if (period_end)
      skip_cnt_q <= (skip_cnt_q + 5'h01 >= skip_target) ? 5'h00 : skip_cnt_q + 5'h01;
  end

  assign burst_request = period_end && (skip_cnt_q + 5'h01 >= skip_target);

  // zoom: awake while detecting, back to sparse bursts once clear
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      awake_q <= 1'b0;
    else if (sample_valid)
      awake_q <= detect_q || (({1'b0, signal_level} + {2'b00, thr_cnt[11:1]})
                  < {1'b0, ref_q});
  end

  // threshold magnitude
  always_comb
  begin
    unique case (cfg_q.thresh)
      tomc_pkg::TOMC_THR_SEN_PROX:  thr_cnt = tomc_pkg::THR_SEN_PROX_CNT;
      tomc_pkg::TOMC_THR_STD_PROX:  thr_cnt = tomc_pkg::THR_STD_PROX_CNT;
      tomc_pkg::TOMC_THR_SEN_TOUCH: thr_cnt = tomc_pkg::THR_SEN_TOUCH_CNT;
      tomc_pkg::TOMC_THR_STD_TOUCH: thr_cnt = tomc_pkg::THR_STD_TOUCH_CNT;
    endcase
  end

  // freeze timeout selection; reserved code treated as 15 s
  always_comb
  begin
    unique case (cfg_q.freeze)
      tomc_pkg::TOMC_FRZ_45S:      frz_ms = 16'(tomc_pkg::FRZ45_MS);
      tomc_pkg::TOMC_FRZ_INFINITE: frz_ms = 16'(tomc_pkg::FRZ15_MS);
      default:                     frz_ms = 16'(tomc_pkg::FRZ15_MS);
    endcase
  end

  assign frz_load    = rise;
  // the timer is only loaded at the end of the rise cycle, so ignore done there
  assign frz_expired = detect_q && !rise && frz_done
                       && (cfg_q.freeze != tomc_pkg::TOMC_FRZ_INFINITE);

  tomc_ms_timer u_freeze_timer
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (frz_load),
    .load_ms (frz_ms),
    .tick    (tick),
    .done    (frz_done)
  );

  // reference and detection
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ref_q    <= 12'h000;
      sig_q    <= 12'h000;
      detect_q <= 1'b0;
    end
    else if (sample_valid)
    begin
      sig_q <= signal_level;
      if (ref_q == 12'h000)
        ref_q <= signal_level;
      else if (!detect_q || frz_expired)
      begin
        if (signal_level > ref_q)
          ref_q <= ref_q + 12'h001;
        else if (signal_level < ref_q)
          ref_q <= ref_q - 12'h001;
      end
      detect_q <= (ref_q != 12'h000) && ({1'b0, signal_level} + {1'b0, thr_cnt}
                  < {1'b0, ref_q});
    end
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      detect_prev_q <= 1'b0;
    else
      detect_prev_q <= detect_q;
  end

  assign rise = detect_q && !detect_prev_q;
  assign fall = !detect_q && detect_prev_q;

  // hold timer: latch modes
  always_comb
  begin
    hold_load = 1'b0;
    hold_ms   = 16'(tomc_pkg::LATCH3_MS);
    if (cfg_q.outmode == tomc_pkg::TOMC_OUT_LATCH3 && rise)
      hold_load = 1'b1;
    else if (cfg_q.outmode == tomc_pkg::TOMC_OUT_LATCH30 && (fall || detect_q))
    begin
      hold_load = 1'b1;
      hold_ms   = 16'(tomc_pkg::LATCH30_MS);
    end
  end

  tomc_ms_timer u_hold_timer
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (hold_load),
    .load_ms (hold_ms),
    .tick    (tick),
    .done    (hold_done)
  );

  tomc_ms_timer u_min_high_timer
  (
    .sys_clk (sys_clk),
    .reset_n (reset_n),
    .load    (out_d && !out_q),
    .load_ms (16'(tomc_pkg::MIN_HIGH_MS)),
    .tick    (tick),
    .done    (minh_done)
  );

  // output shaping
  always_comb
  begin
    out_d = out_q;
    unique case (cfg_q.outmode)
      tomc_pkg::TOMC_OUT_ACTIVE:
        out_d = detect_q || (out_q && !minh_done);
      tomc_pkg::TOMC_OUT_TOGGLE:
        if (rise && (!out_q || minh_done))
          out_d = !out_q;
      tomc_pkg::TOMC_OUT_LATCH3:
        out_d = detect_q || (out_q && (!hold_done || !minh_done));
      tomc_pkg::TOMC_OUT_LATCH30:
        out_d = detect_q || (out_q && (!hold_done || hold_load || !minh_done));
    endcase
  end

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      out_q <= 1'b0;
    else
      out_q <= out_d;
  end

  assign detect_output_pin = out_q;

  // apb slave: zero wait states
  assign apb_access = apb_req.psel && apb_req.penable;
  assign apb_wr     = apb_access && apb_req.pwrite;
  assign pready     = 1'b1;

  always_comb
  begin
    unique case (apb_req.paddr)
      tomc_pkg::ADDR_MODE_OPT, tomc_pkg::ADDR_SAMPLE_OPT, tomc_pkg::ADDR_STATUS,
      tomc_pkg::ADDR_SIGNAL, tomc_pkg::ADDR_REF, tomc_pkg::ADDR_OTP_MODE,
      tomc_pkg::ADDR_OTP_SAMPLE: addr_ok = 1'b1;
      default:                   addr_ok = 1'b0;
    endcase
  end

  assign pslverr = apb_access && !addr_ok;

  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (apb_req.psel && !apb_req.penable && !apb_req.pwrite)
    begin
      unique case (apb_req.paddr)
        tomc_pkg::ADDR_MODE_OPT:
          prdata <= {24'h00_0000, cfg_q.power, cfg_q.thresh, cfg_q.freeze, cfg_q.outmode};
        tomc_pkg::ADDR_SAMPLE_OPT:
          prdata <= {29'h0000_0000, cfg_q.fast_sample, cfg_q.fast_transfer, 1'b0};
        tomc_pkg::ADDR_STATUS:
          prdata <= {28'h000_0000, awake_q, frz_expired, out_q, detect_q};
        tomc_pkg::ADDR_SIGNAL:
          prdata <= {20'h0_0000, sig_q};
        tomc_pkg::ADDR_REF:
          prdata <= {20'h0_0000, ref_q};
        tomc_pkg::ADDR_OTP_MODE:
          prdata <= {24'h00_0000, otp_mode_q};
        tomc_pkg::ADDR_OTP_SAMPLE:
          prdata <= {24'h00_0000, otp_sample_q};
        default:
          prdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule
`default_nettype wire

// [testbench/tomc_checker.sv]
// Purpose: port-level assertions for tomc_top
// Assumes: one clock, async active-low reset
// Notes:   bound to every tomc_top instance
`timescale 1ns/1ps
`default_nettype none
module tomc_checker
(
  // clock and reset
  input wire logic                       sys_clk,
  input wire logic                       reset_n,
  // watched ports
  input wire logic                       sample_valid,
  input wire logic                       charge_transfer_fast,
  input wire tomc_pkg::tomc_apb_req_type apb_req,
  input wire logic [31:0]                prdata,
  input wire logic                       pready,
  input wire logic                       pslverr,
  input wire logic                       detect_output_pin
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);

  logic        acc;
  logic        unmapped;
  logic        rate_q;
  logic [19:0] high_q;

  assign acc      = apb_req.psel && apb_req.penable;
  assign unmapped = (apb_req.paddr[1:0] != 2'h0) || (apb_req.paddr > tomc_pkg::ADDR_OTP_SAMPLE);

  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      rate_q <= 1'b0;
    else if (acc && apb_req.pwrite && apb_req.paddr == tomc_pkg::ADDR_SAMPLE_OPT)
      rate_q <= apb_req.pwdata[tomc_pkg::RATE_BIT];

  // cycles the pin has stood high, saturating
  always_ff @(posedge sys_clk or negedge reset_n)
    if (!reset_n)
      high_q <= 20'h0_0000;
    else if (!detect_output_pin)
      high_q <= 20'h0_0000;
    else if (high_q != 20'hF_FFFF)
      high_q <= high_q + 20'h0_0001;

  ready_always_a: assert property (pready)
    else $error("pready low");
  slverr_decode_a: assert property (pslverr == (acc && unmapped))
    else $error("pslverr decode wrong");
  unmapped_zero_a: assert property (acc && unmapped && !apb_req.pwrite |-> prdata == 32'h0000_0000)
    else $error("unmapped read not zero");
  rdata_hold_a: assert property (acc |=> $stable(prdata))
    else $error("read data moved after access");
  rate_follow_a: assert property (
    acc && apb_req.pwrite && apb_req.paddr == tomc_pkg::ADDR_SAMPLE_OPT
    |=> ##1 charge_transfer_fast == rate_q)
    else $error("transfer rate not applied");
  min_high_a: assert property ($fell(detect_output_pin) |-> high_q >= 20'hB_98C0)
    else $error("output high too briefly");
  release_low_a: assert property ($rose(reset_n) |-> !detect_output_pin)
    else $error("output high after reset");
  rise_cause_a: assert property ($rose(detect_output_pin)
    |-> $past(sample_valid) || $past(sample_valid, 2) || $past(sample_valid, 3))
    else $error("output rose without a sample");
  status_pin_a: assert property (
    acc && !apb_req.pwrite && apb_req.paddr == tomc_pkg::ADDR_STATUS
    |-> prdata[1] == $past(detect_output_pin))
    else $error("status output bit differs from pin");
endmodule

bind tomc_top tomc_checker chk
(
  .sys_clk              (sys_clk),
  .reset_n              (reset_n),
  .sample_valid         (sample_valid),
  .charge_transfer_fast (charge_transfer_fast),
  .apb_req              (apb_req),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .detect_output_pin    (detect_output_pin)
);
`default_nettype wire

// [testbench/tomc_load_model.sv]
// Purpose: lamp load hung on the detect output
// Assumes: pin sources current when high
// Notes:   lit only for a driven high level
`timescale 1ns/1ps
`default_nettype none
module tomc_load_model
(
  // pin from the device
  input  wire logic pin,
  // lamp state
  output logic      lit
);
  assign lit = (pin === 1'b1);
endmodule
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench for tomc_top
// Assumes: 40 MHz clock, apb master in bench
// Notes:   long timers are only checked for holding high
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  typedef struct packed {
    logic       wr;
    logic [7:0] addr;
    logic [7:0] data;
    logic       err;
  } tomc_row_type;

  logic                       sys_clk;
  logic                       reset_n;
  logic [7:0]                 mode_opt;
  logic [7:0]                 samp_opt;
  logic [11:0]                signal_level;
  logic                       sample_valid;
  logic                       xfer_fast;
  tomc_pkg::tomc_apb_req_type apb_req;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic                       pin;
  logic                       lit;
  logic                       burst;
  logic                       burst_seen = 1'b0;
  logic [31:0]                rd;
  logic                       err;
  logic [1:0]                 thr;
  int                         fail_count = 0;
  int                         checks_done = 0;
  int                         cycles = 0;
  tomc_row_type               rows [16] = '{
    '{1'b0, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h04, 8'h00, 1'b0}, '{1'b0, 8'h14, 8'h00, 1'b0},
    '{1'b0, 8'h18, 8'h00, 1'b0}, '{1'b1, 8'h14, 8'hFF, 1'b0}, '{1'b0, 8'h14, 8'h00, 1'b0},
    '{1'b0, 8'h1C, 8'h00, 1'b1}, '{1'b1, 8'h1C, 8'h55, 1'b1}, '{1'b1, 8'h00, 8'h55, 1'b0},
    '{1'b0, 8'h00, 8'h55, 1'b0}, '{1'b1, 8'h00, 8'hAA, 1'b0}, '{1'b0, 8'h00, 8'hAA, 1'b0},
    '{1'b1, 8'h00, 8'hFF, 1'b0}, '{1'b0, 8'h00, 8'hFF, 1'b0}, '{1'b1, 8'h04, 8'h06, 1'b0},
    '{1'b0, 8'h04, 8'h06, 1'b0}};

  tomc_top dut
  (
    .sys_clk                   (sys_clk),
    .reset_n                   (reset_n),
    .mode_threshold_options    (mode_opt),
    .sampling_transfer_options (samp_opt),
    .signal_level              (signal_level),
    .sample_valid              (sample_valid),
    .burst_request             (burst),
    .charge_transfer_fast      (xfer_fast),
    .apb_req                   (apb_req),
    .prdata                    (prdata),
    .pready                    (pready),
    .pslverr                   (pslverr),
    .detect_output_pin         (pin)
  );

  tomc_load_model lamp
  (
    .pin (pin),
    .lit (lit)
  );

  initial
  begin
    sys_clk = 1'b0;
    forever #12.5 sys_clk = ~sys_clk;
  end

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk32({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  // holds the request until pready is seen high at an edge
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rdv, output logic errv);
    apb_req.paddr   <= a;
    apb_req.pwrite  <= wr;
    apb_req.pwdata  <= wd;
    apb_req.psel    <= 1'b1;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
    apb_req.penable <= 1'b1;
    do
    begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    rdv = prdata;
    errv = pslverr;
    apb_req.psel    <= 1'b0;
    apb_req.penable <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic sample(input logic [11:0] lvl);
    signal_level <= lvl;
    sample_valid <= 1'b1;
    @(posedge sys_clk);
    sample_valid <= 1'b0;
    repeat (4) @(posedge sys_clk);
  endtask

  task automatic do_reset(input logic [7:0] m, input logic [7:0] s);
    reset_n  <= 1'b0;
    mode_opt <= m;
    samp_opt <= s;
    repeat (10) @(posedge sys_clk);
    chk1(pin, 1'b0);
    reset_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
  endtask

  always @(posedge sys_clk)
  begin
    cycles <= cycles + 1;
    // no sampling period can end within this short run
    if (burst !== 1'b0)
      burst_seen <= 1'b1;
    if (cycles == 5000)
    begin
      fail_count++;
      stop_test();
    end
  end

  initial
  begin
    reset_n      = 1'b0;
    mode_opt     = 8'h00;
    samp_opt     = 8'h00;
    signal_level = 12'h000;
    sample_valid = 1'b0;
    apb_req      = '0;
    @(posedge sys_clk);
    do_reset(8'h00, 8'h00);
    chk1(xfer_fast, 1'b0);
    foreach (rows[i])
    begin
      apb(rows[i].wr, rows[i].addr, {24'h00_0000, rows[i].data}, rd, err);
      chk1(err, rows[i].err);
      if (!rows[i].wr)
        chk32(rd, {24'h00_0000, rows[i].data});
    end
    chk1(xfer_fast, 1'b1);
    apb(1'b1, tomc_pkg::ADDR_SAMPLE_OPT, 32'h0000_0004, rd, err);
    apb(1'b0, tomc_pkg::ADDR_SAMPLE_OPT, 32'h0000_0000, rd, err);
    chk32(rd, 32'h0000_0004);
    chk1(xfer_fast, 1'b0);
    // active mode, standard touch, reference never released
    apb(1'b1, tomc_pkg::ADDR_MODE_OPT, 32'h0000_005C, rd, err);
    sample(12'h800);
    sample(12'h7E0);
    chk1(pin, 1'b0);
    sample(12'h7D0);
    chk1(pin, 1'b1);
    chk1(lit, 1'b1);
    sample(12'h7D0);
    apb(1'b0, tomc_pkg::ADDR_REF, 32'h0000_0000, rd, err);
    chk32(rd, 32'h0000_07FE);
    apb(1'b0, tomc_pkg::ADDR_STATUS, 32'h0000_0000, rd, err);
    chk32({30'h0000_0000, rd[1:0]}, 32'h0000_0003);
    sample(12'h800);
    apb(1'b0, tomc_pkg::ADDR_STATUS, 32'h0000_0000, rd, err);
    chk1(rd[0], 1'b0);
    chk1(pin, 1'b1);
    // toggle, 3 s latch, 30 s latch, each from pin options
    for (int m = 1; m < 4; m++)
    begin
      thr = (m == 1) ? 2'b10 : {m[0], m[0]};
      do_reset({2'b01, thr, 2'b11, m[1:0]}, 8'h04);
      apb(1'b0, tomc_pkg::ADDR_OTP_MODE, 32'h0000_0000, rd, err);
      chk32(rd, {24'h00_0000, 2'b01, thr, 2'b11, m[1:0]});
      chk1(xfer_fast, 1'b0);
      sample(12'h800);
      sample(12'h7FA);
      chk1(pin, m == 1);
      sample(12'h7E8);
      chk1(pin, 1'b1);
      sample(12'h800);
      chk1(pin, 1'b1);
    end
    chk1(burst_seen, 1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
